// ===== verilog/mrzq_pkg.sv
// Package of command codes, mode register addresses and timing counts for the mode register host
package mrzq_pkg;

  // Clock rate of ref_clk_in in MHz
  localparam int unsigned CLK_MHZ = 200;

  // Mode register addresses
  localparam logic [7:0] MR_TEMP      = 8'h04;  // Temperature status register
  localparam logic [7:0] MR_PAT_A     = 8'h20;  // Calibration pattern A
  localparam logic [7:0] MR_PAT_B     = 8'h28;  // Calibration pattern B
  localparam logic [7:0] MR_RESET     = 8'h3f;  // Reset write target
  localparam logic [7:0] MR_ZQ        = 8'h0a;  // Impedance calibration target

  // Reset write operand with equal rising and falling CA levels
  localparam logic [7:0] OP_RESET     = 8'hfc;

  // Impedance calibration operands
  localparam logic [7:0] OP_ZQ_INIT   = 8'hff;
  localparam logic [7:0] OP_ZQ_LONG   = 8'hab;
  localparam logic [7:0] OP_ZQ_SHORT  = 8'h56;
  localparam logic [7:0] OP_ZQ_RESET  = 8'hc3;

  // Temperature status field and hot code
  localparam int unsigned TEMP_LSB    = 0;
  localparam int unsigned TEMP_W      = 3;
  localparam logic [2:0]  TEMP_HOT    = 3'h3;

  // Calibration patterns, bit time 0 in bit 7
  localparam logic [7:0] PAT_A_BITS   = 8'haa;
  localparam logic [7:0] PAT_B_BITS   = 8'h33;

  // Burst length and derived half burst
  localparam int unsigned BURST_LEN   = 8;
  localparam int unsigned HALF_BURST  = BURST_LEN / 2;

  // Default timing figures in clock cycles of the memory clock
  localparam int unsigned WL_CYC      = 6;
  localparam int unsigned RL_CYC      = 10;
  localparam int unsigned WTR_CYC     = 4;
  localparam int unsigned RCD_CYC     = 12;   // tMRRI equals tRCD
  localparam int unsigned MRR_CYC     = 4;
  localparam int unsigned MRW_CYC     = 10;

  // Calibration times in ns, and derived cycle counts (rounded up, least times)
  localparam int unsigned ZQINIT_NS   = 1000;
  localparam int unsigned ZQCL_NS     = 360;
  localparam int unsigned ZQCS_NS     = 90;
  localparam int unsigned ZQRST_NS    = 50;
  localparam int unsigned ZQINIT_CYC  = (ZQINIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ZQCL_CYC    = (ZQCL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ZQCS_CYC    = (ZQCS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ZQRST_CYC   = (ZQRST_NS * CLK_MHZ + 999) / 1000;

  // Boot wait after a reset write, in us
  localparam int unsigned BOOT_US     = 10;
  localparam int unsigned BOOT_CYC    = BOOT_US * CLK_MHZ;

  // Temperature poll period, in ms, and cycles (longest time, rounded down)
  localparam int unsigned POLL_MS     = 16;
  localparam int unsigned POLL_CYC    = POLL_MS * 1000 * CLK_MHZ;

  // Host requests
  typedef enum logic [2:0] {
    MRZQ_REQ_MRR,
    MRZQ_REQ_MRW,
    MRZQ_REQ_RESET,
    MRZQ_REQ_ZQ_INIT,
    MRZQ_REQ_ZQ_LONG,
    MRZQ_REQ_ZQ_SHORT,
    MRZQ_REQ_ZQ_RESET,
    MRZQ_REQ_NONE
  } mrzq_req_t;

endpackage

// ===== verilog/mrzq_capture_mem.sv
// Small memory that keeps the last value read from each mode register
module mrzq_capture_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  input  wire logic          ref_clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [2**AW];  // Storage, not reset

  // Write port and registered read port
  always_ff @(posedge ref_clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule

// ===== verilog/mrzq_host.sv
// Host controller issuing mode register reads, writes, reset and impedance calibration
// Rules of the document that this block and its device work to
// [R01] Hold mode register read after read/write bursts
// [R02] Only no-operations during a register read
// [R03] Wait row-to-column delay after idle power-down
// [R04] Device refreshes temperature status every 32 ms
// [R05] Temperature code 011 flags overheat risk
// [R06] Poll temperature often enough for 2 C margin
// [R07] Pattern reads return fixed eight-beat sequences; the device model gives only bit time 0, on one valid beat
// [R08] Pattern copied across all lines of lane
// [R09] Pattern reads only while device idle
// [R10] Register write encoding on CA bus
// [R11] Writes to read-only registers are ignored
// [R12] Only no-operations during register write time
// [R13] Register write only with all banks precharged
// [R14] Reads allowed with active banks, writes not
// [R15] Reset write returns device to defaults
// [R16] Boot timings kept until reset completes
// [R17] Reset uses steady CA operand, held around
// [R18] Four impedance calibration commands supported
// [R19] Calibrate only idle, termination off, bus quiet
// [R20] Only no-operations during calibration period
// [R21] Clock enable high throughout calibration
// [R22] No overlap of shared-resistor calibrations
// [R23] Register read encoding and data on low byte
module mrzq_host #(
  parameter int unsigned POLL_CYCLES = mrzq_pkg::POLL_CYC,
  parameter int unsigned BOOT_CYCLES = mrzq_pkg::BOOT_CYC,
  parameter int unsigned ZQI_CYCLES  = mrzq_pkg::ZQINIT_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       req_valid_in,    // Request strobe
  input  wire logic [2:0] req_kind_in,     // Request kind, mrzq_req_t
  input  wire logic [7:0] req_addr_in,     // Register address
  input  wire logic [7:0] req_data_in,     // Write operand
  input  wire logic       last_rd_in,      // Array read just issued
  input  wire logic       last_wr_in,      // Array write just issued
  input  wire logic       pd_exit_in,      // Idle power-down just left
  input  wire logic       banks_idle_in,   // All banks precharged
  input  wire logic       zq_grant_in,     // Shared resistor free
  input  wire logic [7:0] dq_in,           // Read data, low byte of first beat
  input  wire logic       dq_valid_in,     // First read beat present
  output logic            req_ready_out,   // Ready for a request
  output logic            req_err_out,     // Request refused, one cycle
  output logic            cs_n_out,        // Chip select, active low
  output logic            cke_out,         // Clock enable
  output logic [9:0]      ca_rise_out,     // CA on rising edge
  output logic [9:0]      ca_fall_out,     // CA on falling edge
  output logic            zq_busy_out,     // Holding the shared resistor
  output logic            rd_done_out,     // Read data present, one cycle
  output logic [7:0]      rd_data_out,     // Read value
  output logic            temp_hot_out,    // Temperature code at or above hot level
  output logic [7:0]      cached_out       // Last captured value of req_addr_in
);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_CMD,
    ST_POST,
    ST_WAIT,
    ST_READ
  } mrzq_st_t;

  // All state in one record
  typedef struct packed {
    mrzq_st_t   st;
    logic [2:0] kind;
    logic [7:0] addr;
    logic [7:0] op;
    logic [31:0] cnt;      // Quiet-time countdown
    logic [7:0] gap;       // Spacing before next register read
    logic [31:0] poll;     // Temperature poll countdown
    logic       poll_req;  // Internal poll pending
    logic       boot;      // Post-reset boot phase
    logic       ready;
    logic       err;
    logic       cs_n;
    logic       cke;
    logic [9:0] ca_r;
    logic [9:0] ca_f;
    logic       zq_busy;
    logic       done;
    logic [7:0] rdata;
    logic       hot;
  } mrzq_state_t;

  mrzq_state_t s_q;  // Registered state
  mrzq_state_t s_d;  // Next state

  logic [7:0] mem_rdata;  // Capture memory read data

  // Encode a register command onto rising and falling CA words
  function automatic logic [19:0] mrzq_enc(input logic rd, input logic [7:0] a,
                                           input logic [7:0] op);
    logic [9:0] r;
    logic [9:0] f;
    // Low six address bits ride the rising edge and the top two the falling edge,
    // so the reset operand leaves every CA line unchanged between the two edges
    r = {a[5:0], rd, 3'h0};
    f = rd ? {8'h00, a[7:6]} : {op, a[7:6]};
    return {r, f};
  endfunction

  // Quiet time for a request kind
  function automatic logic [31:0] mrzq_quiet(input logic [2:0] k);
    logic [31:0] q;
    q = 32'(mrzq_pkg::MRW_CYC);
    unique case (k)
      3'(mrzq_pkg::MRZQ_REQ_RESET):    q = 32'(BOOT_CYCLES);
      3'(mrzq_pkg::MRZQ_REQ_ZQ_INIT):  q = 32'(ZQI_CYCLES);
      3'(mrzq_pkg::MRZQ_REQ_ZQ_LONG):  q = 32'(mrzq_pkg::ZQCL_CYC);
      3'(mrzq_pkg::MRZQ_REQ_ZQ_SHORT): q = 32'(mrzq_pkg::ZQCS_CYC);
      3'(mrzq_pkg::MRZQ_REQ_ZQ_RESET): q = 32'(mrzq_pkg::ZQRST_CYC);
      default:                         q = 32'(mrzq_pkg::MRW_CYC);
    endcase
    return q;
  endfunction

  // Decides whether a request is legal in the current device state
  logic req_ok;
  logic is_zq;
  logic shared_zq;
  logic is_mrr;
  logic [7:0] k_op;

  // Request legality and operand choice
  always_comb begin
    is_mrr    = (req_kind_in == 3'(mrzq_pkg::MRZQ_REQ_MRR));
    is_zq     = (req_kind_in >= 3'(mrzq_pkg::MRZQ_REQ_ZQ_INIT)) &&
                (req_kind_in <= 3'(mrzq_pkg::MRZQ_REQ_ZQ_RESET));
    shared_zq = is_zq && (req_kind_in != 3'(mrzq_pkg::MRZQ_REQ_ZQ_RESET));
    req_ok    = 1'b1;
    if (is_mrr) begin
      // Pattern reads only when idle; other reads may run with active banks
      if ((req_addr_in == mrzq_pkg::MR_PAT_A || req_addr_in == mrzq_pkg::MR_PAT_B) &&
          !banks_idle_in) begin
        req_ok = 1'b0;  // [R09]
      end
    end else if (!banks_idle_in || s_q.boot) begin
      req_ok = 1'b0;  // [R13] [R14] [R16] [R19]
    end
    if (shared_zq && !zq_grant_in) begin
      req_ok = 1'b0;  // [R22]
    end
    if (req_kind_in == 3'(mrzq_pkg::MRZQ_REQ_NONE)) begin
      req_ok = 1'b0;  // Unused code would otherwise go out as a stray register write
    end
    unique case (req_kind_in)
      3'(mrzq_pkg::MRZQ_REQ_RESET):    k_op = mrzq_pkg::OP_RESET;  // [R17]
      3'(mrzq_pkg::MRZQ_REQ_ZQ_INIT):  k_op = mrzq_pkg::OP_ZQ_INIT;  // [R18]
      3'(mrzq_pkg::MRZQ_REQ_ZQ_LONG):  k_op = mrzq_pkg::OP_ZQ_LONG;
      3'(mrzq_pkg::MRZQ_REQ_ZQ_SHORT): k_op = mrzq_pkg::OP_ZQ_SHORT;
      3'(mrzq_pkg::MRZQ_REQ_ZQ_RESET): k_op = mrzq_pkg::OP_ZQ_RESET;
      default:                         k_op = req_data_in;
    endcase
  end

  // Next-state logic of the whole sequencer
  always_comb begin
    s_d       = s_q;
    s_d.err   = 1'b0;
    s_d.done  = 1'b0;
    s_d.cs_n  = 1'b1;  // No-operation by default [R02] [R12] [R20]
    s_d.ca_r  = 10'h000;
    s_d.ca_f  = 10'h000;
    s_d.cke   = 1'b1;  // [R21]

    // Read spacing after bursts and power-down exit
    if (last_wr_in) begin
      s_d.gap = 8'(mrzq_pkg::WL_CYC + 1 + mrzq_pkg::HALF_BURST + mrzq_pkg::WTR_CYC);  // [R01]
    end else if (pd_exit_in && s_q.gap < 8'(mrzq_pkg::RCD_CYC)) begin
      s_d.gap = 8'(mrzq_pkg::RCD_CYC);  // [R03]
    end else if (last_rd_in && s_q.gap < 8'(mrzq_pkg::HALF_BURST)) begin
      s_d.gap = 8'(mrzq_pkg::HALF_BURST);  // [R01]
    end else if (s_q.gap != 8'h00) begin
      s_d.gap = s_q.gap - 8'h01;
    end

    // Temperature poll timer, period chosen for the thermal margin
    if (s_q.poll == 32'h0000_0000) begin
      s_d.poll     = 32'(POLL_CYCLES - 1);  // [R06]
      s_d.poll_req = 1'b1;
    end else begin
      s_d.poll = s_q.poll - 32'h0000_0001;
    end

    unique case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (req_valid_in && s_q.ready) begin
          s_d.ready = 1'b0;
          if (!req_ok) begin
            s_d.err   = 1'b1;  // Refused, stays idle
            s_d.ready = 1'b1;
          end else begin
            s_d.kind    = req_kind_in;
            s_d.addr    = (req_kind_in == 3'(mrzq_pkg::MRZQ_REQ_RESET)) ? mrzq_pkg::MR_RESET :
                          (is_zq ? mrzq_pkg::MR_ZQ : req_addr_in);
            s_d.op      = k_op;
            s_d.zq_busy = shared_zq;  // [R22]
            // Reset holds CA steady one cycle before the command
            s_d.st = (req_kind_in == 3'(mrzq_pkg::MRZQ_REQ_RESET)) ? ST_PRE : ST_CMD;  // [R17]
          end
        end else if (s_q.poll_req && s_q.ready && !s_q.boot) begin
          // Internal temperature status read
          s_d.ready    = 1'b0;
          s_d.poll_req = (s_q.poll == 32'h0000_0000);  // A fresh expiry wins over the clear
          s_d.kind     = 3'(mrzq_pkg::MRZQ_REQ_MRR);
          s_d.addr     = mrzq_pkg::MR_TEMP;  // [R04]
          s_d.st       = ST_CMD;
        end
      end
      ST_PRE: begin
        // Steady CA level before the reset write
        s_d.ca_r = {s_q.op, 2'h0};  // [R17]
        s_d.ca_f = {s_q.op, 2'h0};
        s_d.st   = ST_CMD;
      end
      ST_CMD: begin
        if (s_q.kind == 3'(mrzq_pkg::MRZQ_REQ_MRR) && s_q.gap != 8'h00) begin
          s_d.st = ST_CMD;  // Wait out read spacing [R01] [R03]
        end else begin
          s_d.cs_n = 1'b0;
          {s_d.ca_r, s_d.ca_f} = mrzq_enc(s_q.kind == 3'(mrzq_pkg::MRZQ_REQ_MRR),
                                          s_q.addr, s_q.op);  // [R10] [R23]
          if (s_q.kind == 3'(mrzq_pkg::MRZQ_REQ_MRR)) begin
            s_d.cnt = 32'(mrzq_pkg::RL_CYC + mrzq_pkg::MRR_CYC);  // [R02]
            s_d.st  = ST_READ;
          end else begin
            s_d.cnt  = mrzq_quiet(s_q.kind);  // [R12] [R20]
            s_d.boot = (s_q.kind == 3'(mrzq_pkg::MRZQ_REQ_RESET));  // [R15] [R16]
            s_d.st   = (s_q.kind == 3'(mrzq_pkg::MRZQ_REQ_RESET)) ? ST_POST : ST_WAIT;
          end
        end
      end
      ST_POST: begin
        // Steady CA level after the reset write
        s_d.ca_r = {s_q.op, 2'h0};  // [R17]
        s_d.ca_f = {s_q.op, 2'h0};
        s_d.st   = ST_WAIT;
      end
      ST_WAIT: begin
        // No-operations only while the quiet time runs
        if (s_q.cnt <= 32'h0000_0001) begin
          s_d.cnt     = 32'h0000_0000;
          s_d.zq_busy = 1'b0;
          s_d.boot    = 1'b0;  // [R16]
          s_d.ready   = 1'b1;
          s_d.st      = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;  // [R12] [R20]
        end
      end
      ST_READ: begin
        // Capture the low byte of the first beat
        if (dq_valid_in) begin
          s_d.rdata = dq_in;  // [R23]
          s_d.done  = 1'b1;
          if (s_q.addr == mrzq_pkg::MR_TEMP) begin
            s_d.hot = (dq_in[mrzq_pkg::TEMP_LSB +: mrzq_pkg::TEMP_W] >= mrzq_pkg::TEMP_HOT);  // [R05]
          end
        end
        if (s_q.cnt <= 32'h0000_0001) begin
          s_d.cnt   = 32'h0000_0000;
          s_d.ready = 1'b1;
          s_d.st    = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 32'h0000_0001;  // [R02]
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.cs_n  <= 1'b1;
      s_q.cke   <= 1'b1;
      s_q.ready <= 1'b0;
      s_q.poll  <= 32'(POLL_CYCLES - 1);
    end else begin
      s_q <= s_d;
    end
  end

  // Keeps the last value read from each register, so pattern and temperature reads can be recalled
  mrzq_capture_mem #(
    .AW (8),
    .DW (8)
  ) u_mem (
    .ref_clk_in (ref_clk_in),
    .we_in      (s_d.done),
    .waddr_in   (s_q.addr),
    .wdata_in   (dq_in),
    .raddr_in   (req_addr_in),
    .rdata_out  (mem_rdata)
  );

  // Outputs straight from flip-flops
  assign req_ready_out = s_q.ready;
  assign req_err_out   = s_q.err;
  assign cs_n_out      = s_q.cs_n;
  assign cke_out       = s_q.cke;
  assign ca_rise_out   = s_q.ca_r;
  assign ca_fall_out   = s_q.ca_f;
  assign zq_busy_out   = s_q.zq_busy;
  assign rd_done_out   = s_q.done;
  assign rd_data_out   = s_q.rdata;
  assign temp_hot_out  = s_q.hot;
  assign cached_out    = mem_rdata;

endmodule

// ===== verification/mrzq_dev_model.sv
// Behavioural memory device answering mode register commands seen on the CA bus
module mrzq_dev_model (
  input  wire logic       ref_clk_in,
  input  wire logic       cs_n_in,
  input  wire logic       cke_in,
  input  wire logic [9:0] ca_rise_in,
  input  wire logic [9:0] ca_fall_in,
  output logic      [7:0] dq_out,
  output logic            dq_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mr [256];  // Mode register contents
  logic [7:0] addr;      // Decoded register address
  logic [7:0] rd_val;    // Value waiting for its read beat
  int         lat;       // Cycles left until read data, 0 when idle
  // Power-up defaults, temperature sensor already at the hot code
  initial begin
    foreach (mr[i]) mr[i] = 8'h00;
    mr[mrzq_pkg::MR_TEMP] = {5'h00, mrzq_pkg::TEMP_HOT};
    lat = 0;
    dq_out = 8'h00;
    dq_valid_out = 1'b0;
  end
  // Decode on the rising edge; idle data lines toggle so stale data never matches
  always @(posedge ref_clk_in) begin
    addr = {ca_fall_in[1:0], ca_rise_in[9:4]};
    dq_valid_out <= (lat == 1);
    dq_out <= (lat == 1) ? rd_val : ~dq_out;
    if (lat > 0) lat = lat - 1;
    if (!cs_n_in && cke_in && ca_rise_in[3:0] == 4'h8) begin
      lat = mrzq_pkg::RL_CYC;
      case (addr)
        mrzq_pkg::MR_PAT_A: rd_val = {8{mrzq_pkg::PAT_A_BITS[7]}};
        mrzq_pkg::MR_PAT_B: rd_val = {8{mrzq_pkg::PAT_B_BITS[7]}};
        default:            rd_val = mr[addr];
      endcase
    end
    if (!cs_n_in && cke_in && ca_rise_in[3:0] == 4'h0) begin
      // Reset write restores every register
      if (addr == mrzq_pkg::MR_RESET) begin
        foreach (mr[i]) mr[i] = 8'h00;
        mr[mrzq_pkg::MR_TEMP] = {5'h00, mrzq_pkg::TEMP_HOT};
      end else if (addr != mrzq_pkg::MR_TEMP && addr != mrzq_pkg::MR_ZQ &&
                   addr != mrzq_pkg::MR_PAT_A && addr != mrzq_pkg::MR_PAT_B) begin
        mr[addr] = ca_fall_in[9:2];
      end
    end
  end
endmodule

// ===== verification/mrzq_host_props.sv
// Concurrent checks on the ports of the mode register host
module mrzq_host_props #(
  parameter int unsigned POLL_CYCLES = 50,
  parameter int unsigned BOOT_CYCLES = 20,
  parameter int unsigned ZQI_CYCLES  = 20
) (
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  input wire logic       req_valid_in,
  input wire logic [2:0] req_kind_in,
  input wire logic [7:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  input wire logic       last_rd_in,
  input wire logic       last_wr_in,
  input wire logic       pd_exit_in,
  input wire logic       banks_idle_in,
  input wire logic       zq_grant_in,
  input wire logic       req_ready_out,
  input wire logic       req_err_out,
  input wire logic       cs_n_out,
  input wire logic       cke_out,
  input wire logic [9:0] ca_rise_out,
  input wire logic [9:0] ca_fall_out,
  input wire logic       zq_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  localparam int unsigned WGAP = mrzq_pkg::WL_CYC + 1 + mrzq_pkg::HALF_BURST + mrzq_pkg::WTR_CYC;
  logic [7:0] wr_q, rd_q, pd_q;  // Cycles since array write, array read, power-down exit
  wire logic take  = req_valid_in && req_ready_out;
  wire logic mrr_c = !cs_n_out && ca_rise_out[3:0] == 4'h8;
  wire logic mrw_c = !cs_n_out && ca_rise_out[3:0] == 4'h0;
  wire logic pat   = req_addr_in == mrzq_pkg::MR_PAT_A || req_addr_in == mrzq_pkg::MR_PAT_B;
  // Saturating ages, so a pulse long ago never wraps into a false short gap
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_q <= 8'hff;
      rd_q <= 8'hff;
      pd_q <= 8'hff;
    end else begin
      wr_q <= last_wr_in ? 8'h00 : (wr_q == 8'hff ? wr_q : wr_q + 8'h01);
      rd_q <= last_rd_in ? 8'h00 : (rd_q == 8'hff ? rd_q : rd_q + 8'h01);
      pd_q <= pd_exit_in ? 8'h00 : (pd_q == 8'hff ? pd_q : pd_q + 8'h01);
    end
  end
  // Accepted write request followed by its command two cycles later
  sequence mrw_take_s;
    take && req_kind_in == mrzq_pkg::MRZQ_REQ_MRW && banks_idle_in;
  endsequence
  sequence rst_cmd_s;
    mrw_c && {ca_fall_out[1:0], ca_rise_out[9:4]} == mrzq_pkg::MR_RESET;
  endsequence
  read_spacing_a: assert property (mrr_c |-> rd_q + 9'd1 >= mrzq_pkg::HALF_BURST &&
    wr_q + 9'd1 >= WGAP && pd_q + 9'd1 >= mrzq_pkg::RCD_CYC) else $error("read spacing short");
  read_quiet_a: assert property (mrr_c |=> cs_n_out [*4])
    else $error("command during register read");
  write_quiet_a: assert property (mrw_c && ca_fall_out[9:2] != mrzq_pkg::OP_ZQ_RESET
    |=> cs_n_out [*8] ##1 cs_n_out [*2]) else $error("command during write time");
  write_code_a: assert property (mrw_take_s |-> ##2 mrw_c &&
    ca_fall_out[9:2] == $past(req_data_in, 2) &&
    {ca_fall_out[1:0], ca_rise_out[9:4]} == $past(req_addr_in, 2))
    else $error("write command coding wrong");
  busy_refuse_a: assert property (take && req_kind_in != mrzq_pkg::MRZQ_REQ_MRR &&
    req_kind_in != mrzq_pkg::MRZQ_REQ_NONE && !banks_idle_in |=> req_err_out)
    else $error("write with active banks taken");
  pat_refuse_a: assert property (take && req_kind_in == mrzq_pkg::MRZQ_REQ_MRR && pat
    && !banks_idle_in |=> req_err_out) else $error("pattern read with active banks");
  read_active_a: assert property (take && req_kind_in == mrzq_pkg::MRZQ_REQ_MRR && !pat
    |=> !req_err_out) else $error("plain read refused");
  zq_share_a: assert property (take && req_kind_in >= 3'h3 && req_kind_in <= 3'h5
    && !zq_grant_in |=> req_err_out) else $error("calibration without grant");
  none_refuse_a: assert property (take && req_kind_in == mrzq_pkg::MRZQ_REQ_NONE
    |=> req_err_out) else $error("unused request code taken");
  rst_steady_a: assert property (rst_cmd_s |-> ca_fall_out[9:2] == mrzq_pkg::OP_RESET &&
    ca_rise_out == ca_fall_out && $stable(ca_rise_out) &&
    $stable(ca_fall_out) ##1 $stable(ca_rise_out)) else $error("reset CA not steady");
  zq_quiet_a: assert property ($rose(zq_busy_out) |=> !cs_n_out ##1 cs_n_out [*8])
    else $error("command during calibration");
  cke_high_a: assert property (cke_out)
    else $error("clock enable low");
endmodule

bind mrzq_host mrzq_host_props #(.POLL_CYCLES(POLL_CYCLES), .BOOT_CYCLES(BOOT_CYCLES),
  .ZQI_CYCLES(ZQI_CYCLES)) u_props (.ref_clk_in, .rst_n_in, .req_valid_in, .req_kind_in,
  .req_addr_in, .req_data_in, .last_rd_in, .last_wr_in, .pd_exit_in, .banks_idle_in,
  .zq_grant_in, .req_ready_out, .req_err_out, .cs_n_out, .cke_out, .ca_rise_out,
  .ca_fall_out, .zq_busy_out);

// ===== verification/tb.sv
// Self-checking bench for the mode register host against a device model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_in, rst_n_in, req_valid_in, last_rd_in, last_wr_in, pd_exit_in;
  logic       banks_idle_in, zq_grant_in, dq_valid_in, req_ready_out, req_err_out;
  logic       cs_n_out, cke_out, zq_busy_out, rd_done_out, temp_hot_out;
  logic [2:0] req_kind_in;
  logic [7:0] req_addr_in, req_data_in, dq_in, rd_data_out, cached_out, op;
  logic [9:0] ca_rise_out, ca_fall_out;
  logic [8:0] exp_q [$];  // Expected results, bit 8 marks a refusal
  int         err_total, comparisons;
  // Long poll period keeps unplanned reads out of the short run
  mrzq_host #(.POLL_CYCLES(60000), .BOOT_CYCLES(20), .ZQI_CYCLES(20)) uut (.ref_clk_in,
    .rst_n_in, .req_valid_in, .req_kind_in, .req_addr_in, .req_data_in, .last_rd_in,
    .last_wr_in, .pd_exit_in, .banks_idle_in, .zq_grant_in, .dq_in, .dq_valid_in,
    .req_ready_out, .req_err_out, .cs_n_out, .cke_out, .ca_rise_out, .ca_fall_out,
    .zq_busy_out, .rd_done_out, .rd_data_out, .temp_hot_out, .cached_out);
  mrzq_dev_model dev (.ref_clk_in, .cs_n_in(cs_n_out), .cke_in(cke_out),
    .ca_rise_in(ca_rise_out), .ca_fall_in(ca_fall_out), .dq_out(dq_in),
    .dq_valid_out(dq_valid_in));
  // 200 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait for the host to accept
  task automatic wait_rdy;
    for (int n = 0; n < 3000 && req_ready_out !== 1'b1; n++) @(negedge ref_clk_in);
  endtask
  // One request held over one accepting edge; 9'h1ff means no result expected
  task automatic req(input mrzq_pkg::mrzq_req_t k, input logic [7:0] a, input logic [8:0] w);
    wait_rdy;
    if (w != 9'h1ff) exp_q.push_back(w);
    req_valid_in = 1'b1;
    req_kind_in = k;
    req_addr_in = a;
    req_data_in = op;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    @(negedge ref_clk_in);  // Idle cycle, so the next call never re-raises valid in this step
  endtask
  // Result watcher: each done or refusal takes the oldest note
  always @(negedge ref_clk_in) begin
    if (rst_n_in === 1'b1 && (rd_done_out === 1'b1 || req_err_out === 1'b1))
      check(req_err_out ? 9'h100 : {1'b0, rd_data_out},
            exp_q.size() > 0 ? exp_q.pop_front() : 9'bx);
  end
  // Hang guard, far beyond the planned run
  initial begin
    #100000;
    err_total++;
    finish_test;
  end
  initial begin
    {req_valid_in, last_rd_in, last_wr_in, pd_exit_in, zq_grant_in, req_data_in} = 13'h0000;
    {banks_idle_in, req_kind_in, req_addr_in, op, rst_n_in} = 21'h100000;
    void'($urandom(27464));
    repeat (4) @(negedge ref_clk_in);
    check({7'h00, cke_out, cs_n_out}, 9'h003);
    rst_n_in = 1'b1;
    zq_grant_in = 1'b1;
    req(mrzq_pkg::MRZQ_REQ_MRR, mrzq_pkg::MR_PAT_A, {1'b0, {8{mrzq_pkg::PAT_A_BITS[7]}}});
    req(mrzq_pkg::MRZQ_REQ_MRR, mrzq_pkg::MR_PAT_B, {1'b0, {8{mrzq_pkg::PAT_B_BITS[7]}}});
    req(mrzq_pkg::MRZQ_REQ_MRR, mrzq_pkg::MR_TEMP, {6'h00, mrzq_pkg::TEMP_HOT});
    // Random writes, each read back right after a burst or power-down exit pulse
    for (int i = 0; i < 3; i++) begin
      op = 8'($urandom) | 8'h80;  // Never equal to the temperature code
      req(mrzq_pkg::MRZQ_REQ_MRW, 8'h11, 9'h1ff);
      wait_rdy;
      {pd_exit_in, last_rd_in, last_wr_in} = 3'(1 << i);
      @(negedge ref_clk_in);
      {pd_exit_in, last_rd_in, last_wr_in} = 3'h0;
      req(mrzq_pkg::MRZQ_REQ_MRR, 8'h11, {1'b0, op});
    end
    req(mrzq_pkg::MRZQ_REQ_MRW, mrzq_pkg::MR_TEMP, 9'h1ff);
    req(mrzq_pkg::MRZQ_REQ_MRR, mrzq_pkg::MR_TEMP, {6'h00, mrzq_pkg::TEMP_HOT});
    wait_rdy;
    check({8'h00, temp_hot_out}, 9'h001);
    // Active banks: writes, reset and calibration refused, plain reads still served
    banks_idle_in = 1'b0;
    req(mrzq_pkg::MRZQ_REQ_MRW, 8'h11, 9'h100);
    req(mrzq_pkg::MRZQ_REQ_RESET, 8'h00, 9'h100);
    req(mrzq_pkg::MRZQ_REQ_ZQ_SHORT, 8'h00, 9'h100);
    req(mrzq_pkg::MRZQ_REQ_MRR, mrzq_pkg::MR_PAT_A, 9'h100);
    req(mrzq_pkg::MRZQ_REQ_MRR, 8'h11, {1'b0, op});
    wait_rdy;
    banks_idle_in = 1'b1;
    req(mrzq_pkg::MRZQ_REQ_NONE, 8'h11, 9'h100);
    // Every calibration kind with the resistor free, then with it held elsewhere
    for (int k = 3; k <= 6; k++) req(mrzq_pkg::mrzq_req_t'(k), 8'h00, 9'h1ff);
    zq_grant_in = 1'b0;
    for (int k = 3; k <= 6; k++)
      req(mrzq_pkg::mrzq_req_t'(k), 8'h00, k == 6 ? 9'h1ff : 9'h100);
    wait_rdy;
    zq_grant_in = 1'b1;
    req(mrzq_pkg::MRZQ_REQ_RESET, 8'h00, 9'h1ff);
    req(mrzq_pkg::MRZQ_REQ_MRR, 8'h11, 9'h000);
    wait_rdy;
    repeat (20) @(negedge ref_clk_in);
    req_addr_in = mrzq_pkg::MR_PAT_A;
    repeat (2) @(negedge ref_clk_in);
    check({1'b0, cached_out}, {1'b0, {8{mrzq_pkg::PAT_A_BITS[7]}}});
    check(9'(exp_q.size()), 9'h000);
    finish_test;
  end
endmodule
